// [hw/sdo_pkg.sv]
// Purpose: Shared constants and carriers for the safety drive output image decoder
// Assumes: Output image arrives as eleven bytes, bit n.m = byte n bit m
// Notes:   Diagnostic codes are 16 bits wide
package sdo_pkg;
  localparam int          IMG_BYTES        = 11;
  localparam int          IMG_BITS         = IMG_BYTES * 8;
  localparam int          POS_PATH_ONE     = 0;
  localparam int          POS_PATH_TWO     = 1;
  localparam int          POS_SWOFF_ACK    = 2;
  localparam int          POS_STAGE_EN     = 3;
  localparam int          POS_BRAKE_REL    = 4;
  localparam int          POS_BRAKE_ACK    = 5;
  localparam int          POS_ENC_ACK      = 16;
  localparam int          POS_GROUP_FAULT  = 32;
  localparam int          POS_RSVD_FIRST   = 48;
  localparam int          POS_DIAG_FIRST   = 64;
  localparam int          DIAG_COUNT       = 16;
  localparam int          POS_FB_ENABLE    = 80;
  localparam int          POS_FB_ACK       = 81;
  localparam int          POS_FB_SETREF    = 82;
  localparam logic [15:0] DIAG_CODE_BASE   = 16'hD300;
  localparam logic [15:0] DIAG_CODE_LAST   = 16'hD30F;
  localparam logic [7:0]  STATION_ADDR_RST = 8'h00;
  localparam logic [15:0] STATION_ADDR_IDX = 16'hF980;
  localparam logic [7:0]  STATION_ADDR_SUB = 8'h01;

  typedef struct packed {
    logic path_one_enable;
    logic path_two_enable;
    logic output_stage_enable;
    logic brake_release;
    logic group_fault;
    logic feedback_enable;
  } drive_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } diag_entry_t;

  typedef enum logic [1:0] {
    FLT_CLEAR   = 2'b01,
    FLT_LATCHED = 2'b10
  } flt_state_t;
endpackage

// [hw/safety_drive_output_image.sv]
// Purpose: Decodes the safety logic output image into drive actions and fault flags
// Assumes: Image is produced by logic on clk_in; fault conditions come from pins
// Notes:   One diagnostic entry is logged per cycle, lowest index first
// Summary of operation
// - Bit 0.0 enables first switch-off path
// - Bit 0.1 enables second switch-off path
// - Bit 0.2 acknowledges switch-off path fault
// - Bit 0.3 signals output stage enable
// - Bit 0.4 releases brake, low locks
// - Bit 0.5 acknowledges brake control fault
// - Bit 2.0 acknowledges encoder supply fault
// - Bit 4.0 forwarded as group fault
// - Falling diag bit logs code 0xD300 plus index
// - Bit 10.0 enables primary feedback
// - Bit 10.1 acknowledges primary feedback fault
// - Bit 10.2 requests feedback reference set
// - Active station address readable, updated when applied
// - Switch-off path fault flag reported to logic
// - Brake control fault flag reported to logic
`timescale 1ns/10ps
module safety_drive_output_image (
  input  wire logic                         clk_in,              // Logic cycle clock, 250 MHz
  input  wire logic                         nrst_in,             // Async reset, active low
  input  wire logic                         ce_in,               // Clock enable, freezes state when low
  input  wire logic [sdo_pkg::IMG_BITS-1:0] out_image_in,        // Output process image from safety logic
  input  wire logic                         swoff_fault_cond_in, // Raw switch-off path fault (pin)
  input  wire logic                         brake_fault_cond_in, // Raw brake control fault (pin)
  input  wire logic                         enc_fault_cond_in,   // Raw encoder supply fault (pin)
  input  wire logic                         fb_fault_cond_in,    // Raw primary feedback fault (pin)
  input  wire logic [7:0]                   new_addr_in,         // Downloaded station address
  input  wire logic                         new_addr_apply_in,   // Apply downloaded address, pulse
  output logic                              switch_off_path_one_enable_out,   // Path one enable
  output logic                              switch_off_path_two_enable_out,   // Path two enable
  output logic                              output_stage_enable_to_drive_out, // Output stage enable
  output logic                              holding_brake_release_out,        // Brake released when high
  output logic                              group_fault_to_drive_out,         // Group fault status
  output logic                              primary_feedback_enable_out,      // Feedback module enable
  output logic                              primary_feedback_set_reference_out, // Set reference pulse
  output logic                              switch_off_fault_flag_out,        // Latched path fault
  output logic                              holding_brake_fault_flag_out,     // Latched brake fault
  output logic                              encoder_supply_fault_flag_out,    // Latched encoder fault
  output logic                              primary_feedback_fault_flag_out,  // Latched feedback fault
  output logic                              diag_valid_out,      // Diagnostic entry valid, pulse
  output logic [15:0]                       diag_code_out,       // Diagnostic message code
  output logic [7:0]                        station_addr_out     // Active station address
);
  // Pin synchronisers
  logic [3:0] flt_meta_ff;
  logic [3:0] flt_sync_ff;
  logic [8:0] addr_meta_ff;
  logic [8:0] addr_sync_ff;
  logic       addr_apply_prev_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flt_meta_ff        <= 4'h0;
      flt_sync_ff        <= 4'h0;
      addr_meta_ff       <= 9'h000;
      addr_sync_ff       <= 9'h000;
      addr_apply_prev_ff <= 1'b0;
    end else if (ce_in) begin
      flt_meta_ff        <= {fb_fault_cond_in, enc_fault_cond_in, brake_fault_cond_in, swoff_fault_cond_in};
      flt_sync_ff        <= flt_meta_ff;
      addr_meta_ff       <= {new_addr_apply_in, new_addr_in};
      addr_sync_ff       <= addr_meta_ff;
      addr_apply_prev_ff <= addr_sync_ff[8];
    end
  end

  // Command decode; byte 6 is never read
  sdo_pkg::drive_cmd_t nxt_cmd;
  sdo_pkg::drive_cmd_t cmd_ff;
  assign nxt_cmd.path_one_enable     = out_image_in[sdo_pkg::POS_PATH_ONE];
  assign nxt_cmd.path_two_enable     = out_image_in[sdo_pkg::POS_PATH_TWO];
  assign nxt_cmd.output_stage_enable = out_image_in[sdo_pkg::POS_STAGE_EN];
  assign nxt_cmd.brake_release       = out_image_in[sdo_pkg::POS_BRAKE_REL];
  assign nxt_cmd.group_fault         = out_image_in[sdo_pkg::POS_GROUP_FAULT];
  assign nxt_cmd.feedback_enable     = out_image_in[sdo_pkg::POS_FB_ENABLE];

  wire [3:0] ack_req = {out_image_in[sdo_pkg::POS_FB_ACK],
                        out_image_in[sdo_pkg::POS_ENC_ACK],
                        out_image_in[sdo_pkg::POS_BRAKE_ACK],
                        out_image_in[sdo_pkg::POS_SWOFF_ACK]};
  wire       setref_req = out_image_in[sdo_pkg::POS_FB_SETREF];
  wire [sdo_pkg::DIAG_COUNT-1:0] diag_bits = out_image_in[sdo_pkg::POS_DIAG_FIRST +: sdo_pkg::DIAG_COUNT];

  logic                          setref_prev_ff;
  logic                          setref_ff;
  logic [sdo_pkg::DIAG_COUNT-1:0] diag_prev_ff;
  logic [sdo_pkg::DIAG_COUNT-1:0] diag_pend_ff;
  sdo_pkg::diag_entry_t           diag_ff;
  logic [7:0]                     addr_ff;

  // Lowest set bit index
  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  wire [15:0] diag_fall    = diag_prev_ff & ~diag_bits;
  wire [15:0] diag_all     = diag_pend_ff | diag_fall;
  wire [3:0]  diag_idx     = first_set(diag_all);
  wire        diag_any     = |diag_all;
  wire [15:0] diag_clr     = diag_any ? (16'h0001 << diag_idx) : 16'h0000;
  wire [15:0] nxt_diag_pend = diag_all & ~diag_clr;
  wire [15:0] nxt_diag_code = sdo_pkg::DIAG_CODE_BASE + {12'h000, diag_idx};
  wire        addr_apply   = addr_sync_ff[8] & ~addr_apply_prev_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_ff         <= '0;
      setref_prev_ff <= 1'b0;
      setref_ff      <= 1'b0;
      diag_prev_ff   <= 16'h0000;
      diag_pend_ff   <= 16'h0000;
      diag_ff        <= '0;
      addr_ff        <= sdo_pkg::STATION_ADDR_RST;
    end else if (ce_in) begin
      cmd_ff         <= nxt_cmd;
      setref_prev_ff <= setref_req;
      setref_ff      <= setref_req & ~setref_prev_ff;
      diag_prev_ff   <= diag_bits;
      diag_pend_ff   <= nxt_diag_pend;
      diag_ff.valid  <= diag_any;
      diag_ff.code   <= diag_any ? nxt_diag_code : diag_ff.code;
      if (addr_apply) begin
        addr_ff <= addr_sync_ff[7:0];
      end
    end
  end

  // Fault latches: condition sets, acknowledge clears only once gone
  sdo_pkg::flt_state_t flt_st_ff [4];
  for (genvar g = 0; g < 4; g++) begin : g_flt
    sdo_pkg::flt_state_t nxt_flt_st;
    always_comb begin
      nxt_flt_st = flt_st_ff[g];
      unique case (flt_st_ff[g])
        sdo_pkg::FLT_CLEAR: begin
          if (flt_sync_ff[g]) begin
            nxt_flt_st = sdo_pkg::FLT_LATCHED;
          end
        end
        sdo_pkg::FLT_LATCHED: begin
          if (ack_req[g] && !flt_sync_ff[g]) begin
            nxt_flt_st = sdo_pkg::FLT_CLEAR;
          end
        end
        default: nxt_flt_st = sdo_pkg::FLT_LATCHED;
      endcase
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        flt_st_ff[g] <= sdo_pkg::FLT_CLEAR;
      end else if (ce_in) begin
        flt_st_ff[g] <= nxt_flt_st;
      end
    end
  end

  assign switch_off_path_one_enable_out     = cmd_ff.path_one_enable;
  assign switch_off_path_two_enable_out     = cmd_ff.path_two_enable;
  assign output_stage_enable_to_drive_out   = cmd_ff.output_stage_enable;
  assign holding_brake_release_out          = cmd_ff.brake_release;
  assign group_fault_to_drive_out           = cmd_ff.group_fault;
  assign primary_feedback_enable_out        = cmd_ff.feedback_enable;
  assign primary_feedback_set_reference_out = setref_ff;
  assign switch_off_fault_flag_out          = (flt_st_ff[0] == sdo_pkg::FLT_LATCHED);
  assign holding_brake_fault_flag_out       = (flt_st_ff[1] == sdo_pkg::FLT_LATCHED);
  assign encoder_supply_fault_flag_out      = (flt_st_ff[2] == sdo_pkg::FLT_LATCHED);
  assign primary_feedback_fault_flag_out    = (flt_st_ff[3] == sdo_pkg::FLT_LATCHED);
  assign diag_valid_out                     = diag_ff.valid;
  assign diag_code_out                      = diag_ff.code;
  assign station_addr_out                   = addr_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_PATH_ONE: assert property (ce_in |=> switch_off_path_one_enable_out ==
                                 $past(out_image_in[sdo_pkg::POS_PATH_ONE]))
    else $error("path one enable mismatch");
  AST_PATH_TWO: assert property (ce_in |=> switch_off_path_two_enable_out ==
                                 $past(out_image_in[sdo_pkg::POS_PATH_TWO]))
    else $error("path two enable mismatch");
  AST_STAGE: assert property (ce_in |=> output_stage_enable_to_drive_out ==
                              $past(out_image_in[sdo_pkg::POS_STAGE_EN]))
    else $error("output stage enable mismatch");
  AST_BRAKE: assert property (ce_in |=> holding_brake_release_out ==
                              $past(out_image_in[sdo_pkg::POS_BRAKE_REL]))
    else $error("brake release mismatch");
  AST_GROUP: assert property (ce_in |=> group_fault_to_drive_out ==
                              $past(out_image_in[sdo_pkg::POS_GROUP_FAULT]))
    else $error("group fault mismatch");
  AST_FB_EN: assert property (ce_in |=> primary_feedback_enable_out ==
                              $past(out_image_in[sdo_pkg::POS_FB_ENABLE]))
    else $error("feedback enable mismatch");
  AST_SETREF: assert property (ce_in && out_image_in[sdo_pkg::POS_FB_SETREF] && !setref_prev_ff
                               |=> primary_feedback_set_reference_out)
    else $error("set reference not issued");
  AST_DIAG_CODE: assert property (diag_valid_out |-> diag_code_out >= sdo_pkg::DIAG_CODE_BASE &&
                                  diag_code_out <= sdo_pkg::DIAG_CODE_LAST)
    else $error("diag code out of range");
  AST_DIAG_FALL0: assert property (ce_in && diag_prev_ff[0] && !out_image_in[sdo_pkg::POS_DIAG_FIRST]
                                   |=> diag_valid_out && diag_code_out == sdo_pkg::DIAG_CODE_BASE)
    else $error("falling bit 0 not logged");
  AST_FREEZE: assert property (!ce_in |=> $stable(cmd_ff) && $stable(diag_ff) && $stable(setref_ff) &&
                               $stable(switch_off_fault_flag_out) && $stable(station_addr_out))
    else $error("state moved while clock enable low");
  AST_SWOFF_HOLD: assert property (ce_in && switch_off_fault_flag_out && flt_sync_ff[0]
                                   |=> switch_off_fault_flag_out)
    else $error("fault cleared while present");
  AST_SWOFF_ACK: assert property (ce_in && switch_off_fault_flag_out && out_image_in[sdo_pkg::POS_SWOFF_ACK] &&
                                  !flt_sync_ff[0]
                                  |=> !switch_off_fault_flag_out)
    else $error("switch-off ack ignored");
  AST_BRAKE_ACK: assert property (ce_in && holding_brake_fault_flag_out && out_image_in[sdo_pkg::POS_BRAKE_ACK] &&
                                  !flt_sync_ff[1]
                                  |=> !holding_brake_fault_flag_out)
    else $error("brake ack ignored");
  AST_ENC_ACK: assert property (ce_in && encoder_supply_fault_flag_out && out_image_in[sdo_pkg::POS_ENC_ACK] &&
                                !flt_sync_ff[2]
                                |=> !encoder_supply_fault_flag_out)
    else $error("encoder ack ignored");
  AST_FB_ACK: assert property (ce_in && primary_feedback_fault_flag_out && out_image_in[sdo_pkg::POS_FB_ACK] &&
                               !flt_sync_ff[3]
                               |=> !primary_feedback_fault_flag_out)
    else $error("feedback ack ignored");
  AST_SWOFF_SET: assert property (ce_in && flt_sync_ff[0] |=> switch_off_fault_flag_out)
    else $error("switch-off fault not flagged");
  AST_BRAKE_SET: assert property (ce_in && flt_sync_ff[1] |=> holding_brake_fault_flag_out)
    else $error("brake fault not flagged");
  AST_ADDR: assert property (ce_in && addr_apply |=> station_addr_out == $past(addr_sync_ff[7:0]))
    else $error("station address not applied");

  COV_DIAG: cover property (diag_valid_out && diag_code_out == sdo_pkg::DIAG_CODE_LAST);
  COV_ACK: cover property (switch_off_fault_flag_out ##1 !switch_off_fault_flag_out);
  COV_BRAKE: cover property (holding_brake_release_out ##1 !holding_brake_release_out);
  COV_ADDR: cover property (addr_apply);
endmodule

// [tb/drive_side_model.sv]
// Purpose: Far-side model of power stage, brake and encoder fault sources
// Assumes: Fault injection is commanded by the bench per fault index
// Notes:   Index 0 switch-off, 1 brake, 2 encoder, 3 feedback
`timescale 1ns/10ps
module drive_side_model (
  input  wire logic       clk_in,         // Logic cycle clock
  input  wire logic       nrst_in,        // Async reset, active low
  input  wire logic [3:0] inject_in,      // Commanded fault conditions
  output logic      [3:0] fault_cond_out  // Raw fault conditions to the decoder
);
  // One flop of far-side delay, so conditions are never aligned to the bench edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) fault_cond_out <= 4'h0;
    else fault_cond_out <= inject_in;
  end
endmodule

// [tb/safety_drive_output_image_test.sv]
// Purpose: Self-checking bench for the output image decoder
// Assumes: Inputs change at the falling edge; monitor samples 1 ns after the rising edge, most direct checks at the falling edge
// Notes:   Level and diagnostic results go through queues checked by a monitor
`timescale 1ns/10ps
module safety_drive_output_image_test;
  logic clk_in, nrst_in, apply, ce;
  logic [sdo_pkg::IMG_BITS-1:0] img;
  logic [3:0]  inject, cond, fl;
  logic [7:0]  addr, new_addr;
  logic [15:0] code, mask;
  logic sw1, sw2, stg, brk, grp, fbe, sref, dvalid;
  int err_total, tests_run, n;
  sdo_pkg::drive_cmd_t lvl_q[$];
  logic [15:0]         diag_q[$];
  int ack_pos[4] = '{sdo_pkg::POS_SWOFF_ACK, sdo_pkg::POS_BRAKE_ACK, sdo_pkg::POS_ENC_ACK, sdo_pkg::POS_FB_ACK};

  safety_drive_output_image dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce), .out_image_in(img),
    .swoff_fault_cond_in(cond[0]), .brake_fault_cond_in(cond[1]), .enc_fault_cond_in(cond[2]),
    .fb_fault_cond_in(cond[3]), .new_addr_in(new_addr), .new_addr_apply_in(apply),
    .switch_off_path_one_enable_out(sw1), .switch_off_path_two_enable_out(sw2),
    .output_stage_enable_to_drive_out(stg), .holding_brake_release_out(brk), .group_fault_to_drive_out(grp),
    .primary_feedback_enable_out(fbe), .primary_feedback_set_reference_out(sref),
    .switch_off_fault_flag_out(fl[0]), .holding_brake_fault_flag_out(fl[1]),
    .encoder_supply_fault_flag_out(fl[2]), .primary_feedback_fault_flag_out(fl[3]),
    .diag_valid_out(dvalid), .diag_code_out(code), .station_addr_out(addr));
  drive_side_model far (.clk_in(clk_in), .nrst_in(nrst_in), .inject_in(inject), .fault_cond_out(cond));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    tests_run++;
    if (a !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic cmp_cmd(input sdo_pkg::drive_cmd_t a, input sdo_pkg::drive_cmd_t e);
    cmp({10'h000, a}, {10'h000, e});
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Monitor: takes the oldest note whenever a result is due or appears
  always @(posedge clk_in) begin
    #1;
    if (lvl_q.size() > 0) cmp_cmd({sw1, sw2, stg, brk, grp, fbe}, lvl_q.pop_front());
    if (dvalid === 1'b1) begin
      if (diag_q.size() > 0) cmp(code, diag_q.pop_front());
      else cmp(code, 16'hFFFF);
    end
  end

  initial begin
    img = '0;
    inject = 4'h0;
    apply = 1'b0;
    ce = 1'b1;
    new_addr = 8'h00;
    nrst_in = 1'b0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'h3b43));
    step(3);
    nrst_in = 1'b1;
    step(1);
    cmp({8'h00, addr}, {8'h00, sdo_pkg::STATION_ADDR_RST});
    cmp({12'h000, fl}, 16'h0000);
    // Random images; byte 6 varies without effect on levels, diagnostic bits held low
    for (int i = 0; i < 40; i++) begin
      img = 88'({$urandom, $urandom, $urandom});
      img[79:64] = 16'h0000;
      lvl_q.push_back({img[sdo_pkg::POS_PATH_ONE], img[sdo_pkg::POS_PATH_TWO], img[sdo_pkg::POS_STAGE_EN],
        img[sdo_pkg::POS_BRAKE_REL], img[sdo_pkg::POS_GROUP_FAULT], img[sdo_pkg::POS_FB_ENABLE]});
      step(1);
    end
    img = '0;
    step(2);
    // Low clock enable holds the command levels and set-reference output while the image moves
    ce = 1'b0;
    img = '1;
    step(3);
    cmp_cmd({sw1, sw2, stg, brk, grp, fbe}, '0);
    cmp({15'h0000, sref}, 16'h0000);
    img = '0;
    ce = 1'b1;
    step(2);
    // Falls of several diagnostic bits at once queue lowest index first
    for (int r = 0; r < 4; r++) begin
      mask = (r == 0) ? 16'h0000 : 16'($urandom);
      img[79:64] = 16'hFFFF;
      step(1);
      img[79:64] = mask;
      for (int i = 0; i < sdo_pkg::DIAG_COUNT; i++)
        if (!mask[i]) diag_q.push_back(sdo_pkg::DIAG_CODE_BASE + 16'(i));
      step(20);
    end
    cmp(16'(diag_q.size()), 16'h0000);
    // Clearing the image drops the bits still high in the last mask
    for (int i = 0; i < sdo_pkg::DIAG_COUNT; i++)
      if (mask[i]) diag_q.push_back(sdo_pkg::DIAG_CODE_BASE + 16'(i));
    img = '0;
    step(20);
    cmp(16'(diag_q.size()), 16'h0000);
    // Set-reference edge gives a single pulse while the bit stays high
    img[sdo_pkg::POS_FB_SETREF] = 1'b1;
    @(posedge clk_in) #1 cmp({15'h0000, sref}, 16'h0001);
    @(posedge clk_in) #1 cmp({15'h0000, sref}, 16'h0000);
    step(1);
    img = '0;
    // Each fault: ack ignored while present, flag kept after it goes, cleared by ack
    for (int k = 0; k < 4; k++) begin
      inject[k] = 1'b1;
      step(6);
      cmp({15'h0000, fl[k]}, 16'h0001);
      img[ack_pos[k]] = 1'b1;
      step(3);
      cmp({15'h0000, fl[k]}, 16'h0001);
      img[ack_pos[k]] = 1'b0;
      inject[k] = 1'b0;
      step(6);
      cmp({15'h0000, fl[k]}, 16'h0001);
      img[ack_pos[k]] = 1'b1;
      step(2);
      cmp({15'h0000, fl[k]}, 16'h0000);
      img[ack_pos[k]] = 1'b0;
    end
    // Downloaded station address becomes the active one once applied
    for (int j = 0; j < 3; j++) begin
      new_addr = addr ^ (8'($urandom) | 8'h01);
      apply = 1'b1;
      n = 0;
      while (addr !== new_addr && n < 10) begin
        step(1);
        n++;
      end
      cmp({8'h00, addr}, {8'h00, new_addr});
      apply = 1'b0;
      step(4);
    end
    print_verdict();
  end
endmodule
